// *** rtl/csb_core.sv ***
// small processor core: stack, flags, branches and subroutine handling
`timescale 1ns/1ns
module csb_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // memory bus
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic mem_rd,
  output logic mem_wr,
  // maskable interrupt request pin
  input wire logic irq_n,
  // register view
  output logic [7:0] accumulator,
  output logic [15:0] index_pair,
  output logic [15:0] stack_top_pointer,
  output logic [15:0] program_counter,
  output logic [7:0] flag_register
);

  // ==========================================
  // state
  csb_pkg::csb_state_t state_reg;
  logic [7:0] acc_reg;
  logic [15:0] index_reg;
  logic [15:0] sp_reg;
  logic [15:0] pc_reg;
  logic [7:0] flag_reg;
  logic [7:0] op_reg;
  logic [7:0] op1_reg;
  logic [7:0] op2_reg;
  logic [15:0] ea_reg;
  logic [2:0] idx_reg;
  logic [2:0] cnt_reg;
  logic [7:0] stk_buf [0:csb_pkg::STK_DEPTH-1];
  logic irq_meta_reg;
  logic irq_sync_reg;
  logic take_int;
  logic [15:0] rel_target;
  logic [8:0] sum9;
  logic [4:0] half5;

  assign accumulator = acc_reg;
  assign index_pair = index_reg;
  assign stack_top_pointer = sp_reg;
  assign program_counter = pc_reg;
  assign flag_register = flag_reg;

  // ==========================================
  // interrupt pin synchroniser
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_meta_reg <= 1'b1;
      irq_sync_reg <= 1'b1;
    end else begin
      irq_meta_reg <= irq_n;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  assign take_int = !irq_sync_reg && !flag_reg[csb_pkg::FLG_I];
  assign rel_target = pc_reg + {{8{op1_reg[7]}}, op1_reg};
  assign sum9 = {1'b0, acc_reg} + {1'b0, op1_reg};
  assign half5 = {1'b0, acc_reg[3:0]} + {1'b0, op1_reg[3:0]};

  // ==========================================
  // memory bus
  always_comb begin
    mem_addr = pc_reg;
    mem_wdata = 8'h00;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    case (state_reg)
      csb_pkg::S_FETCH: mem_rd = !take_int;
      csb_pkg::S_OPER: mem_rd = 1'b1;
      csb_pkg::S_MEM: begin
        mem_addr = ea_reg;
        mem_rd = 1'b1;
      end
      csb_pkg::S_PUSH: begin
        mem_addr = sp_reg;
        mem_wdata = stk_buf[idx_reg];
        mem_wr = 1'b1;
      end
      csb_pkg::S_PULL_RD: begin
        mem_addr = sp_reg;
        mem_rd = 1'b1;
      end
      default: mem_rd = 1'b0;
    endcase
  end

  // ==========================================
  // sequencer and programmer registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= csb_pkg::S_FETCH;
      acc_reg <= 8'h00;
      index_reg <= 16'h0000;
      sp_reg <= csb_pkg::SP_RESET;
      pc_reg <= csb_pkg::PC_RESET;
      flag_reg <= csb_pkg::FLAG_RESET;
      op_reg <= 8'h00;
      op1_reg <= 8'h00;
      op2_reg <= 8'h00;
      ea_reg <= 16'h0000;
      idx_reg <= 3'h0;
      cnt_reg <= 3'h0;
      for (int i = 0; i < csb_pkg::STK_DEPTH; i++) begin
        stk_buf[i] <= 8'h00;
      end
    end else begin
      case (state_reg)
        csb_pkg::S_FETCH: begin
          idx_reg <= 3'h0;
          if (take_int) begin
            stk_buf[0] <= pc_reg[7:0];
            stk_buf[1] <= pc_reg[15:8];
            stk_buf[2] <= index_reg[15:8];
            stk_buf[3] <= index_reg[7:0];
            stk_buf[4] <= acc_reg;
            stk_buf[5] <= flag_reg;
            cnt_reg <= csb_pkg::LAST_INT;
            op_reg <= csb_pkg::OP_INT_ENTRY;
            state_reg <= csb_pkg::S_PUSH;
          end else begin
            op_reg <= mem_rdata;
            pc_reg <= pc_reg + 16'h0001;
            state_reg <= (csb_pkg::op_len(mem_rdata) != 2'h0) ? csb_pkg::S_OPER : csb_pkg::S_EXEC;
          end
        end
        csb_pkg::S_OPER: begin
          if (idx_reg == 3'h0) begin
            op1_reg <= mem_rdata;
          end else begin
            op2_reg <= mem_rdata;
          end
          pc_reg <= pc_reg + 16'h0001;
          if ({1'b0, csb_pkg::op_len(op_reg)} == idx_reg + 3'h1) begin
            idx_reg <= 3'h0;
            state_reg <= csb_pkg::S_EXEC;
          end else begin
            idx_reg <= idx_reg + 3'h1;
          end
        end
        csb_pkg::S_EXEC: begin
          state_reg <= csb_pkg::S_FETCH;
          case (op_reg)
            csb_pkg::OP_LDA_IMM: begin
              acc_reg <= op1_reg;
              flag_reg <= csb_pkg::set_nz(flag_reg, op1_reg);
            end
            csb_pkg::OP_AND_IMM: begin
              acc_reg <= acc_reg & op1_reg;
              flag_reg <= csb_pkg::set_nz(flag_reg, acc_reg & op1_reg);
            end
            csb_pkg::OP_ADD_IMM: begin
              acc_reg <= sum9[7:0];
              flag_reg <= {(acc_reg[7] == op1_reg[7]) && (sum9[7] != acc_reg[7]), flag_reg[6:5], half5[4],
                flag_reg[csb_pkg::FLG_I], sum9[7], sum9[7:0] == 8'h00, sum9[8]};
            end
            csb_pkg::OP_LDX_IMM: index_reg[7:0] <= op1_reg;
            csb_pkg::OP_LDH_IMM: index_reg[15:8] <= op1_reg;
            csb_pkg::OP_LDA_DIR: begin
              ea_reg <= {csb_pkg::DIRECT_PAGE, op1_reg};
              state_reg <= csb_pkg::S_MEM;
            end
            csb_pkg::OP_LDA_SP: begin
              ea_reg <= sp_reg + {8'h00, op1_reg};
              state_reg <= csb_pkg::S_MEM;
            end
            csb_pkg::OP_PSHA: begin
              stk_buf[0] <= acc_reg;
              cnt_reg <= csb_pkg::LAST_ONE;
              state_reg <= csb_pkg::S_PUSH;
            end
            csb_pkg::OP_JSR, csb_pkg::OP_BSR: begin
              stk_buf[0] <= pc_reg[7:0];
              stk_buf[1] <= pc_reg[15:8];
              cnt_reg <= csb_pkg::LAST_TWO;
              state_reg <= csb_pkg::S_PUSH;
            end
            csb_pkg::OP_PULA: begin
              cnt_reg <= csb_pkg::LAST_ONE;
              state_reg <= csb_pkg::S_PULL_INC;
            end
            csb_pkg::OP_RTS: begin
              cnt_reg <= csb_pkg::LAST_TWO;
              state_reg <= csb_pkg::S_PULL_INC;
            end
            csb_pkg::OP_RTI: begin
              cnt_reg <= csb_pkg::LAST_INT;
              state_reg <= csb_pkg::S_PULL_INC;
            end
            csb_pkg::OP_BRA: pc_reg <= rel_target;
            csb_pkg::OP_BEQ: pc_reg <= flag_reg[csb_pkg::FLG_Z] ? rel_target : pc_reg;
            csb_pkg::OP_SEI: flag_reg[csb_pkg::FLG_I] <= 1'b1;
            csb_pkg::OP_CLI: flag_reg[csb_pkg::FLG_I] <= 1'b0;
            default: state_reg <= csb_pkg::S_FETCH;
          endcase
        end
        csb_pkg::S_MEM: begin
          acc_reg <= mem_rdata;
          flag_reg <= csb_pkg::set_nz(flag_reg, mem_rdata);
          state_reg <= csb_pkg::S_FETCH;
        end
        // pointer moves to next free byte
        csb_pkg::S_PUSH: begin
          sp_reg <= sp_reg - 16'h0001;
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == cnt_reg) begin
            state_reg <= csb_pkg::S_FINISH;
          end
        end
        csb_pkg::S_PULL_INC: begin
          sp_reg <= sp_reg + 16'h0001;
          state_reg <= csb_pkg::S_PULL_RD;
        end
        csb_pkg::S_PULL_RD: begin
          stk_buf[idx_reg] <= mem_rdata;
          if (idx_reg == cnt_reg) begin
            state_reg <= csb_pkg::S_FINISH;
          end else begin
            idx_reg <= idx_reg + 3'h1;
            state_reg <= csb_pkg::S_PULL_INC;
          end
        end
        csb_pkg::S_FINISH: begin
          state_reg <= csb_pkg::S_FETCH;
          case (op_reg)
            csb_pkg::OP_JSR: pc_reg <= {op1_reg, op2_reg};
            csb_pkg::OP_BSR: pc_reg <= rel_target;
            csb_pkg::OP_INT_ENTRY: begin
              pc_reg <= csb_pkg::INT_VECTOR;
              flag_reg[csb_pkg::FLG_I] <= 1'b1;
            end
            csb_pkg::OP_RTS: pc_reg <= {stk_buf[0], stk_buf[1]};
            csb_pkg::OP_PULA: acc_reg <= stk_buf[0];
            csb_pkg::OP_RTI: begin
              flag_reg <= stk_buf[0];
              acc_reg <= stk_buf[1];
              index_reg <= {stk_buf[3], stk_buf[2]};
              pc_reg <= {stk_buf[4], stk_buf[5]};
            end
            default: state_reg <= csb_pkg::S_FETCH;
          endcase
        end
        default: state_reg <= csb_pkg::S_FETCH;
      endcase
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_neg_flag;
    state_reg == csb_pkg::S_EXEC && op_reg == csb_pkg::OP_LDA_IMM |=> flag_reg[csb_pkg::FLG_N] == acc_reg[7];
  endproperty
  a_neg_flag: assert property (p_neg_flag) else $error("negative flag wrong");

  property p_zero_flag;
    state_reg == csb_pkg::S_MEM |=> flag_reg[csb_pkg::FLG_Z] == (acc_reg == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_pull_order;
    state_reg == csb_pkg::S_PULL_RD |-> mem_rd && mem_addr == sp_reg && sp_reg == $past(sp_reg) + 16'h0001;
  endproperty
  a_pull_order: assert property (p_pull_order) else $error("pull order wrong");

  property p_push_order;
    state_reg == csb_pkg::S_PUSH |-> mem_wr && mem_addr == sp_reg ##1 sp_reg == $past(sp_reg) - 16'h0001;
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order wrong");

  property p_call_low_first;
    state_reg == csb_pkg::S_PUSH && op_reg == csb_pkg::OP_JSR && idx_reg == 3'h0
      |-> mem_wdata == pc_reg[7:0] ##1 mem_wdata == pc_reg[15:8];
  endproperty
  a_call_low_first: assert property (p_call_low_first) else $error("return address order wrong");

  property p_return;
    state_reg == csb_pkg::S_FINISH && op_reg == csb_pkg::OP_RTS |=> pc_reg == {$past(stk_buf[0]), $past(stk_buf[1])};
  endproperty
  a_return: assert property (p_return) else $error("return address not restored");

  property p_int_save;
    state_reg == csb_pkg::S_FETCH && take_int |=> mem_wr [*6];
  endproperty
  a_int_save: assert property (p_int_save) else $error("interrupt entry did not stack six bytes");

  property p_branch_taken;
    state_reg == csb_pkg::S_EXEC && op_reg == csb_pkg::OP_BRA
      |=> pc_reg == $past(pc_reg) + {{8{$past(op1_reg[7])}}, $past(op1_reg)};
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("branch target wrong");

  property p_branch_not_taken;
    state_reg == csb_pkg::S_EXEC && op_reg == csb_pkg::OP_BEQ && !flag_reg[csb_pkg::FLG_Z] |=> $stable(pc_reg);
  endproperty
  a_branch_not_taken: assert property (p_branch_not_taken) else $error("untaken branch moved counter");

  property p_sp_relative;
    state_reg == csb_pkg::S_MEM && op_reg == csb_pkg::OP_LDA_SP |-> mem_addr == sp_reg + {8'h00, op1_reg};
  endproperty
  a_sp_relative: assert property (p_sp_relative) else $error("stack relative address wrong");

  property p_direct_page;
    state_reg == csb_pkg::S_MEM && op_reg == csb_pkg::OP_LDA_DIR |-> mem_addr[15:8] == csb_pkg::DIRECT_PAGE;
  endproperty
  a_direct_page: assert property (p_direct_page) else $error("direct address outside page");

  property p_mask;
    state_reg == csb_pkg::S_FETCH && flag_reg[csb_pkg::FLG_I] |-> mem_rd ##1 state_reg != csb_pkg::S_PUSH;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt taken");

  property p_one_strobe;
    !(mem_rd && mem_wr);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("read and write together");

endmodule

// *** rtl/csb_pkg.sv ***
// constants, states and decode helpers for the small stack and branch core
// How it works
// - the negative flag is set when an operation result has its top bit set.
// - the zero flag is set when an operation result byte is all zeros.
// - a pull first increments the stack pointer and then reads at its new value.
// - a push writes at the stack pointer and then decrements it.
// - the stack pointer always addresses the next free stack byte.
// - a subroutine call pushes the return address low byte first, then high byte.
// - a subroutine return restores the program counter from the stacked address.
// - interrupt entry stacks the program counter, index pair, accumulator and flags, but not the stack pointer.
// - a taken relative branch adds the sign-extended displacement to the program counter.
// - an untaken relative branch leaves the program counter unchanged.
// - stack-relative operands sit at the stack pointer plus an unsigned offset byte.
// - the core holds an 8-bit accumulator and 16-bit index pair, stack pointer and program counter.
// - the flag register holds overflow, half-carry, interrupt mask, negative, zero and carry.
// - the index pair can be loaded as a separate low byte and high byte.
// - direct addressing reaches addresses 0 to 255 with a one-byte operand.
// - with the interrupt mask set, maskable requests are ignored; clear, they are taken.
package csb_pkg;

  // ==========================================
  // flag register bit positions
  localparam int FLG_V = 7;
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;

  // ==========================================
  // reset values and fixed addresses
  localparam logic [7:0] FLAG_RESET = 8'h68;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] PC_RESET = 16'h0100;
  localparam logic [15:0] INT_VECTOR = 16'h0200;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam int STK_DEPTH = 6;
  localparam logic [2:0] LAST_ONE = 3'h0;
  localparam logic [2:0] LAST_TWO = 3'h1;
  localparam logic [2:0] LAST_INT = 3'h5;

  // ==========================================
  // opcodes
  localparam logic [7:0] OP_LDA_IMM = 8'ha6;
  localparam logic [7:0] OP_ADD_IMM = 8'hab;
  localparam logic [7:0] OP_AND_IMM = 8'ha4;
  localparam logic [7:0] OP_LDX_IMM = 8'hae;
  localparam logic [7:0] OP_LDH_IMM = 8'ha5;
  localparam logic [7:0] OP_LDA_DIR = 8'hb6;
  localparam logic [7:0] OP_LDA_SP = 8'he6;
  localparam logic [7:0] OP_PSHA = 8'h87;
  localparam logic [7:0] OP_PULA = 8'h86;
  localparam logic [7:0] OP_JSR = 8'hcd;
  localparam logic [7:0] OP_BSR = 8'had;
  localparam logic [7:0] OP_RTS = 8'h81;
  localparam logic [7:0] OP_RTI = 8'h80;
  localparam logic [7:0] OP_BRA = 8'h20;
  localparam logic [7:0] OP_BEQ = 8'h27;
  localparam logic [7:0] OP_SEI = 8'h9b;
  localparam logic [7:0] OP_CLI = 8'h9a;
  localparam logic [7:0] OP_INT_ENTRY = 8'h83;

  typedef enum logic [2:0] {
    S_FETCH, S_OPER, S_EXEC, S_MEM, S_PUSH, S_PULL_INC, S_PULL_RD, S_FINISH
  } csb_state_t;

  // operand bytes following an opcode
  function automatic logic [1:0] op_len(input logic [7:0] op);
    case (op)
      OP_JSR: op_len = 2'h2;
      OP_LDA_IMM, OP_ADD_IMM, OP_AND_IMM, OP_LDX_IMM, OP_LDH_IMM,
      OP_LDA_DIR, OP_LDA_SP, OP_BSR, OP_BRA, OP_BEQ: op_len = 2'h1;
      default: op_len = 2'h0;
    endcase
  endfunction

  // negative and zero update of a result byte
  function automatic logic [7:0] set_nz(input logic [7:0] flags, input logic [7:0] res);
    logic [7:0] f;
    f = flags;
    f[FLG_N] = res[7];
    f[FLG_Z] = (res == 8'h00);
    set_nz = f;
  endfunction

endpackage

// *** test/csb_core_tb.sv ***
// self-checking bench for the stack and branch core
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module csb_core_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic irq_n = 1'b0;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] accumulator;
  logic [15:0] index_pair;
  logic [15:0] stack_top_pointer;
  logic [15:0] program_counter;
  logic [7:0] flag_register;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] prog [0:32] = '{8'ha6, 8'h80, 8'ha4, 8'h00, 8'hae, 8'h34, 8'ha5, 8'h12, 8'ha6, 8'h5a, 8'h87,
    8'ha6, 8'h00, 8'he6, 8'h01, 8'hb6, 8'h40, 8'h86, 8'hcd, 8'h03, 8'h00, 8'h27, 8'h05, 8'h20, 8'h03,
    8'h20, 8'hfe, 8'h9d, 8'had, 8'hd2, 8'h9a, 8'h20, 8'hfe};

  always #50 sys_clk = ~sys_clk;

  csb_core uut (.sys_clk(sys_clk), .reset_n(reset_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .irq_n(irq_n), .accumulator(accumulator),
    .index_pair(index_pair), .stack_top_pointer(stack_top_pointer), .program_counter(program_counter),
    .flag_register(flag_register));

  csb_mem_model mem_u (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_rdata(mem_rdata));

  // ==========================================
  // verdict
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================
  // wait for an opcode fetch at an address
  task automatic cp(input logic [15:0] a);
    int n;
    logic hit;
    n = 0;
    @(negedge sys_clk);
    while (!(mem_rd === 1'b1 && mem_addr === a) && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    hit = (mem_rd === 1'b1 && mem_addr === a);
    `CHK("fetch reached", 1'b1, hit)
  endtask

  // register view compare
  task automatic regs(input logic [7:0] a, input logic [15:0] x, input logic [15:0] s, input logic [7:0] f);
    `CHK("accumulator", a, accumulator)
    `CHK("index_pair", x, index_pair)
    `CHK("stack_top_pointer", s, stack_top_pointer)
    `CHK("flag_register", f, flag_register)
  endtask

  // ==========================================
  // bus strobes never overlap, timeout
  always @(negedge sys_clk) begin
    if (mem_rd === 1'b1 && mem_wr === 1'b1) begin
      failures++;
      $display("ERROR strobes expected %h seen %h", 1'b0, mem_wr);
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("ERROR run length expected %h seen %h", 1'b0, 1'b1);
      test_done();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    #1;
    for (int i = 0; i < 33; i++) begin
      mem_u.mem[16'h0100 + i] = prog[i];
    end
    mem_u.mem[16'h0040] = 8'h81;
    mem_u.mem[16'h00f0] = 8'h81;
    mem_u.mem[16'h0300] = 8'h81;
    mem_u.mem[16'h0200] = 8'hab;
    mem_u.mem[16'h0201] = 8'h7f;
    mem_u.mem[16'h0202] = 8'hab;
    mem_u.mem[16'h0203] = 8'h30;
    mem_u.mem[16'h0204] = 8'h80;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    regs(8'h00, 16'h0000, 16'h00ff, 8'h68);
    `CHK("program_counter", 16'h0100, program_counter)
    `CHK("mem_wr", 1'b0, mem_wr)
    @(posedge sys_clk);
    reset_n <= 1'b1;
    cp(16'h0102);
    regs(8'h80, 16'h0000, 16'h00ff, 8'h6c);
    cp(16'h0104);
    regs(8'h00, 16'h0000, 16'h00ff, 8'h6a);
    cp(16'h0108);
    regs(8'h00, 16'h1234, 16'h00ff, 8'h6a);
    cp(16'h010b);
    regs(8'h5a, 16'h1234, 16'h00fe, 8'h68);
    `CHK("pushed byte", 8'h5a, mem_u.mem[16'h00ff])
    cp(16'h010f);
    regs(8'h5a, 16'h1234, 16'h00fe, 8'h68);
    cp(16'h0111);
    regs(8'h81, 16'h1234, 16'h00fe, 8'h6c);
    cp(16'h0112);
    regs(8'h5a, 16'h1234, 16'h00ff, 8'h6c);
    cp(16'h0300);
    `CHK("sp after call", 16'h00fd, stack_top_pointer)
    `CHK("return low", 8'h15, mem_u.mem[16'h00ff])
    `CHK("return high", 8'h01, mem_u.mem[16'h00fe])
    cp(16'h0115);
    `CHK("sp after return", 16'h00ff, stack_top_pointer)
    cp(16'h0117);
    cp(16'h011c);
    cp(16'h00f0);
    `CHK("routine return low", 8'h1e, mem_u.mem[16'h00ff])
    `CHK("sp in routine", 16'h00fd, stack_top_pointer)
    cp(16'h011e);
    regs(8'h5a, 16'h1234, 16'h00ff, 8'h6c);
    cp(16'h0200);
    regs(8'h5a, 16'h1234, 16'h00f9, 8'h6c);
    `CHK("stacked pc low", 8'h1f, mem_u.mem[16'h00ff])
    `CHK("stacked pc high", 8'h01, mem_u.mem[16'h00fe])
    `CHK("stacked index high", 8'h12, mem_u.mem[16'h00fd])
    `CHK("stacked index low", 8'h34, mem_u.mem[16'h00fc])
    `CHK("stacked accumulator", 8'h5a, mem_u.mem[16'h00fb])
    `CHK("stacked flags", 8'h64, mem_u.mem[16'h00fa])
    @(posedge sys_clk);
    irq_n <= 1'b1;
    cp(16'h0202);
    regs(8'hd9, 16'h1234, 16'h00f9, 8'hfc);
    cp(16'h0204);
    regs(8'h09, 16'h1234, 16'h00f9, 8'h69);
    cp(16'h011f);
    regs(8'h5a, 16'h1234, 16'h00ff, 8'h64);
    test_done();
  end
endmodule

// *** test/csb_mem_model.sv ***
// memory model on the far side of the core bus
`timescale 1ns/1ns
module csb_mem_model (
  // clock
  input wire logic sys_clk,
  // bus from the core
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  // read data back to the core
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h00;

  // ==========================================
  // unused locations decode as no-operation
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h9d;
    end
  end

  // ==========================================
  // asynchronous read, unselected bus shows the inverse of the last byte
  assign mem_rdata = (mem_rd === 1'b1) ? mem[mem_addr] : ~last_reg;

  // ==========================================
  // store on the write strobe, remember the last byte read
  always @(posedge sys_clk) begin
    if (mem_rd === 1'b1) begin
      last_reg <= mem[mem_addr];
    end
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule
